// ### bench/acs_dev_model.sv
`timescale 1ns/10ps
module acs_dev_model (
  input  wire logic             clk,   // system clock
  input  wire logic             rstn,  // reset, active low
  input  wire acs_pkg::acs_dreq_s req, // register strobes
  output logic [7:0]            rdata, // read data
  output int                    bad    // breaches by the host
);
  import acs_pkg::*;
  localparam logic [11:0] RES = 12'ha5c;
  localparam logic [11:0] CAL = 12'h9b3; // arbitrary value
  logic [7:0] r [8];
  int         busyCnt, tsAge, pwAge;
  wire [2:0]  src = r[3][7:5];
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '{default: 8'h00};
      r[4] <= ACS_TEMP_RESET;
      r[5] <= ACS_BG_RESET;
      {busyCnt, tsAge, pwAge, bad} <= '0;
      rdata <= 8'h00;
    end else begin
      tsAge <= tsAge + 1;
      pwAge <= pwAge + 1;
      // released line shows the inverse of its last value
      rdata <= ~rdata;
      if (req.re) rdata <= req.addr == 6 ? CAL[11:4] :
                           req.addr == 7 ? {CAL[3:0], 4'h0} : r[req.addr];
      if (busyCnt > 0) busyCnt <= busyCnt - 1;
      if (busyCnt == 1) begin
        r[2][6] <= 1'b0;
        if (r[2][5]) {r[1], r[0]} <= r[2][4] ? {4'h0, RES} : {RES, 4'h0};
      end
      if (req.we && req.addr inside {[2:5]}) begin
        r[req.addr] <= req.wdata;
        if (req.addr == 2) r[2][6] <= r[2][6];
        if (req.addr == 4 && !req.wdata[1]) bad <= bad + 1;
        if (req.addr == 4 && req.wdata[0] && !r[4][0]) tsAge <= 0;
        if (req.addr == 3 && req.wdata[7:5] == 3'h7) bad <= bad + 1;
        if (req.addr == 2 && req.wdata[5] && !r[2][5]) pwAge <= 0;
        if (req.addr == 2 && r[2][7] && !req.wdata[7]) begin
          if (r[2][6] || pwAge < ACS_POWERUP_CYC || !req.wdata[5]) bad <= bad + 1;
          if (src inside {[1:4]} && !req.wdata[3]) bad <= bad + 1;
          if (src == 1 && !r[5][0]) bad <= bad + 1;
          if ((src == 2 || r[3][4:3] == 2) && tsAge < ACS_SETTLE_CYC) bad <= bad + 1;
          busyCnt <= (src == 2 ? 58 : 16) << r[3][2:0];
          r[2][6] <= 1'b1;
        end
      end
    end
  end
endmodule : acs_dev_model

// ### bench/tb_acs_host.sv
`timescale 1ns/10ps
module tb_acs_host;
  import acs_pkg::*;
  logic        clk = 0, rstn = 0, hwrite = 0, hreadyout, hresp, regRefPathSwitch;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, d;
  logic [7:0]  devRdata;
  acs_dreq_s   devReq;
  int          err_count, cmp_count, cyc, bad;
  logic [31:0] cfgs [6] = '{32'h0818, 32'h19f98, 32'h10801, 32'h2b02, 32'h0807, 32'h0600};
  // with auto power-off, done is seen while the power-off write is still pending
  logic [31:0] exst [6] = '{32'h2, 32'h3, 32'h2, 32'h2, 32'h4, 32'h4};
  acs_host uut (.clk(clk), .rstn(rstn), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .devRdata(devRdata),
    .devReq(devReq), .regRefPathSwitch(regRefPathSwitch));
  acs_dev_model dev (.clk(clk), .rstn(rstn), .req(devReq), .rdata(devRdata), .bad(bad));
  always #25 clk = ~clk;
  task conclude();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  always @(posedge clk) if (++cyc > 40000) begin
    err_count++;
    conclude();
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task wait_end();
    do xfer(0, ACS_STAT_OFS, 0, d); while (d[2:1] === 2'b00);
  endtask : wait_end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1;
    repeat (2) @(posedge clk);
    xfer(0, ACS_STAT_OFS, 0, d);
    chk(d & 32'h3f, 32'h0);
    for (int i = 0; i < 6; i++) begin
      xfer(1, ACS_CFG_OFS, cfgs[i], d);
      xfer(1, ACS_CMD_OFS, 32'h1, d);
      if (i == 0) xfer(1, ACS_CMD_OFS, 32'h1, d);
      wait_end();
      chk(d & 32'h7, exst[i]);
      xfer(0, ACS_RES_OFS, 0, d);
      if (exst[i][1]) chk(d, 32'ha5c);
      if (i == 1) chk(regRefPathSwitch, 32'h0);
      if (i == 2) chk(regRefPathSwitch, 32'h1);
      xfer(1, ACS_STAT_OFS, 32'h6, d);
      if (i == 1) xfer(0, ACS_STAT_OFS, 0, d);
      if (i == 1) chk(d & 32'h3f, 32'h0);
      $display("convert case %0d finished", i);
    end
    xfer(1, ACS_CMD_OFS, 32'h2, d);
    wait_end();
    xfer(0, ACS_CAL_OFS, 0, d);
    chk(d, 32'h9b3);
    xfer(1, 8'h14, 32'hffff, d);
    xfer(0, 8'h14, 0, d);
    chk(d, 32'h0);
    chk(bad, 32'h0);
    $display("calibration and unmapped cases finished");
    rstn <= 1'b0;
    @(posedge clk);
    chk(hreadyout, 32'h0);
    chk(devReq, 32'h0);
    chk(regRefPathSwitch, 32'h0);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    xfer(0, ACS_CFG_OFS, 0, d);
    chk(d, 32'h0);
    $display("mid-run reset case finished");
    conclude();
  end
endmodule : tb_acs_host

// ### hw/acs_ahb_slave.sv
`timescale 1ns/10ps
module acs_ahb_slave
  import acs_pkg::*;
(
  input  wire logic                          clk,       // system clock
  input  wire logic                          rstn,      // async reset, active low
  input  wire logic                          ce,        // clock enable
  input  wire logic                          hsel,      // slave select
  input  wire logic [31:0]                   haddr,     // byte address
  input  wire logic [1:0]                    htrans,    // transfer type
  input  wire logic                          hwrite,    // write when high
  input  wire logic [2:0]                    hsize,     // transfer size
  input  wire logic [31:0]                   hwdata,    // write data
  input  wire logic                          hready,    // bus ready
  input  wire logic [ACS_NUM_REGS-1:0][31:0] rdWords,   // register read values
  output logic [31:0]                        hrdata,    // read data
  output logic                               hreadyout, // slave ready
  output logic                               hresp,     // always okay
  output logic                               wrEn,      // register write strobe
  output logic [2:0]                         wrIdx,     // register index written
  output logic [31:0]                        wrData     // register write data
);
  logic       dphWr;
  logic [2:0] dphIdx;
  logic       dphHit;
  logic       accept;
  logic       hit;

  assign accept = hsel && htrans[1] && hready;
  assign hit    = (haddr[7:5] == 3'h0) && (haddr[4:2] < 3'(ACS_NUM_REGS));

  // only whole-word single transfers are expected; hsize is not decoded
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dphWr     <= 1'b0;
      dphIdx    <= 3'h0;
      dphHit    <= 1'b0;
      hrdata    <= 32'h0;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      dphWr     <= accept && hwrite;
      dphIdx    <= haddr[4:2];
      dphHit    <= hit;
      if (accept && !hwrite) begin
        hrdata <= hit ? rdWords[haddr[4:2]] : 32'h0;
      end
    end
  end

  assign wrEn   = ce && dphWr && dphHit;
  assign wrIdx  = dphIdx;
  assign wrData = hwdata;

endmodule : acs_ahb_slave

// ### hw/acs_dev_port.sv
`timescale 1ns/10ps
module acs_dev_port
  import acs_pkg::*;
(
  input  wire logic       clk,      // system clock
  input  wire logic       rstn,     // async reset, active low
  input  wire logic       ce,       // clock enable
  input  wire logic       reqValid, // one-cycle access request
  input  wire acs_dreq_s  req,      // access kind, index and data
  input  wire logic [7:0] devRdata, // device read data
  output acs_dreq_s       devReq,   // strobes to the device
  output logic            done,     // one-cycle completion pulse
  output logic [7:0]      rdata     // captured read data
);
  acs_port_e pst;

  // device answers a read one cycle after its read strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pst    <= P_IDLE;
      devReq <= '0;
      done   <= 1'b0;
      rdata  <= 8'h0;
    end else if (ce) begin
      done <= 1'b0;
      case (pst)
        P_IDLE: begin
          if (reqValid) begin
            devReq <= req;
            pst    <= P_ACT;
          end
        end
        P_ACT: begin
          devReq.we <= 1'b0;
          devReq.re <= 1'b0;
          if (devReq.re) begin
            pst <= P_CAP;
          end else begin
            done <= 1'b1;
            pst  <= P_IDLE;
          end
        end
        P_CAP: begin
          rdata <= devRdata;
          done  <= 1'b1;
          pst   <= P_IDLE;
        end
        default: pst <= P_IDLE;
      endcase
    end
  end

endmodule : acs_dev_port

// ### hw/acs_host.sv
`timescale 1ns/10ps
module acs_host
  import acs_pkg::*;
(
  input  wire logic        clk,               // system clock, 20 MHz
  input  wire logic        rstn,              // async reset, active low
  input  wire logic        ce,                // clock enable
  input  wire logic        hsel,              // slave select
  input  wire logic [31:0] haddr,             // byte address
  input  wire logic [1:0]  htrans,            // transfer type
  input  wire logic        hwrite,            // write when high
  input  wire logic [2:0]  hsize,             // transfer size
  input  wire logic [31:0] hwdata,            // write data
  input  wire logic        hready,            // bus ready
  output logic [31:0]      hrdata,            // read data
  output logic             hreadyout,         // slave ready
  output logic             hresp,             // response, always okay
  input  wire logic [7:0]  devRdata,          // device read data
  output acs_dreq_s        devReq,            // device register strobes
  output logic             regRefPathSwitch   // regulator reference path switch
);
  import acs_pkg::*;

  acs_cfg_s                  cfg;
  acs_cfg_s                  act;
  acs_state_e                state;
  logic                      doneSticky;
  logic                      errSticky;
  logic                      devBusy;
  logic                      tsOn;
  logic                      pwrOn;
  logic                      bgOn;
  logic [1:0]                devRef;
  logic [ACS_CNT_W-1:0]      settleCnt;
  logic [ACS_CNT_W-1:0]      pwrCnt;
  logic [11:0]               result;
  logic [11:0]               calib;
  logic [7:0]                hiByte;
  logic                      reqValid;
  acs_dreq_s                 reqData;
  logic                      issued;
  logic                      portDone;
  logic [7:0]                portRdata;
  logic                      wrEn;
  logic [2:0]                wrIdx;
  logic [31:0]               wrData;
  logic [ACS_NUM_REGS-1:0][31:0] rdWords;
  logic                      seqBusy;
  logic                      cfgBad;
  logic                      isInternal;
  logic                      stepAcc;
  acs_dreq_s                 step;
  logic                      goConv;
  logic                      goCal;
  logic                      clrDone;
  logic                      clrErr;
  logic                      next_regulator_ref_path_switch;

  acs_ahb_slave u_slave (
    .clk       (clk),
    .rstn      (rstn),
    .ce        (ce),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .rdWords   (rdWords),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .wrEn      (wrEn),
    .wrIdx     (wrIdx),
    .wrData    (wrData)
  );

  acs_dev_port u_port (
    .clk      (clk),
    .rstn     (rstn),
    .ce       (ce),
    .reqValid (reqValid),
    .req      (reqData),
    .devRdata (devRdata),
    .devReq   (devReq),
    .done     (portDone),
    .rdata    (portRdata)
  );

  // converter clock period in ns for a divider code
  function automatic int adckNs(input logic [2:0] code);
    adckNs = ACS_CLK_PERIOD_NS << code;
  endfunction : adckNs

  assign seqBusy    = (state != ST_IDLE);
  assign isInternal = (act.src >= ACS_SRC_BG) && (act.src <= ACS_SRC_OPP);
  assign goConv     = wrEn && (wrIdx == ACS_CMD_IDX) && wrData[ACS_CMD_CONV];
  assign goCal      = wrEn && (wrIdx == ACS_CMD_IDX) && wrData[ACS_CMD_CAL];
  assign clrDone    = wrEn && (wrIdx == ACS_STAT_IDX) && wrData[ACS_ST_DONE];
  assign clrErr     = wrEn && (wrIdx == ACS_STAT_IDX) && wrData[ACS_ST_ERR];

  // refuse settings that would break the device's usage limits
  always_comb begin
    cfgBad = 1'b0;
    if (cfg.src == ACS_SRC_FORBID) cfgBad = 1'b1;
    if (cfg.src == ACS_SRC_TSO) begin
      if (!cfg.temp_sensor_enable) cfgBad = 1'b1;
      if (adckNs(cfg.div) < ACS_TSCK_MIN_NS || adckNs(cfg.div) > ACS_TSCK_MAX_NS)
        cfgBad = 1'b1;
    end else if (adckNs(cfg.div) < ACS_ADCK_MIN_NS || adckNs(cfg.div) > ACS_ADCK_MAX_NS) begin
      cfgBad = 1'b1;
    end
    if (cfg.refSel == ACS_REF_TS && !cfg.temp_sensor_enable) cfgBad = 1'b1;
  end

  // register read view
  always_comb begin
    rdWords               = '0;
    rdWords[ACS_CFG_IDX]  = 32'(cfg);
    rdWords[ACS_STAT_IDX] = {26'h0, pwrOn, tsOn, devBusy, errSticky, doneSticky, seqBusy};
    rdWords[ACS_RES_IDX]  = {20'h0, result};
    rdWords[ACS_CAL_IDX]  = {20'h0, calib};
  end

  // device access for each sequencer step except idle and the settle and power-up waits
  always_comb begin
    stepAcc = 1'b1;
    step    = '0;
    case (state)
      ST_BG: begin
        step.we    = 1'b1;
        step.addr  = ACS_DEV_BG;
        step.wdata = {7'h0, act.bgEn | (act.src == ACS_SRC_BG)};
      end
      ST_TEMP: begin
        step.we    = 1'b1;
        step.addr  = ACS_DEV_TEMP;
        step.wdata = {6'h0, 1'b1, act.temp_sensor_enable};
      end
      ST_MAIN, ST_START_HI, ST_START_LO, ST_PWROFF: begin
        step.we                    = 1'b1;
        step.addr                  = ACS_DEV_MAIN;
        step.wdata[ACS_MAIN_START] = (state == ST_START_HI);
        step.wdata[ACS_MAIN_PWR]   = (state != ST_PWROFF);
        step.wdata[ACS_MAIN_ALIGN] = act.align;
        step.wdata[3:0]            = isInternal ? {1'b1, act.chan[2:0]} : act.chan;
      end
      ST_SRC: begin
        step.we    = 1'b1;
        step.addr  = ACS_DEV_SRCCLK;
        step.wdata = {act.src, act.refSel, act.div};
      end
      ST_POLL: begin
        step.re   = 1'b1;
        step.addr = ACS_DEV_MAIN;
      end
      ST_RD_HI, ST_RD_LO: begin
        step.re   = 1'b1;
        step.addr = (state == ST_RD_HI) ? ACS_DEV_RES_HI : ACS_DEV_RES_LO;
      end
      ST_CAL_HI, ST_CAL_LO: begin
        step.re   = 1'b1;
        step.addr = (state == ST_CAL_HI) ? ACS_DEV_CAL_HI : ACS_DEV_CAL_LO;
      end
      default: stepAcc = 1'b0;
    endcase
  end

  // software configuration, locked while a sequence runs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg <= '0;
    end else if (ce && wrEn && wrIdx == ACS_CFG_IDX && !seqBusy) begin
      cfg <= acs_cfg_s'(wrData[$bits(acs_cfg_s)-1:0]);
    end
  end

  // sticky status: a set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      doneSticky <= 1'b0;
      errSticky  <= 1'b0;
    end else if (ce) begin
      if (portDone && (state == ST_RD_LO || state == ST_CAL_LO)) begin
        doneSticky <= 1'b1;
      end else if (clrDone) begin
        doneSticky <= 1'b0;
      end
      if (state == ST_IDLE && goConv && cfgBad) errSticky <= 1'b1;
      else if (clrErr) errSticky <= 1'b0;
    end
  end

  // sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state    <= ST_IDLE;
      act      <= '0;
      reqValid <= 1'b0;
      reqData  <= '0;
      issued   <= 1'b0;
      hiByte   <= 8'h0;
      result   <= 12'h0;
      calib    <= 12'h0;
      devBusy  <= 1'b0;
    end else if (ce) begin
      reqValid <= 1'b0;
      if (stepAcc && !issued) begin
        reqValid <= 1'b1;
        reqData  <= step;
        issued   <= 1'b1;
      end
      if (portDone) issued <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (goConv && !cfgBad) begin
            act   <= cfg;
            state <= ST_BG;
          end else if (goCal) begin
            state <= ST_CAL_HI;
          end
        end
        ST_BG:     if (portDone) state <= ST_TEMP;
        ST_TEMP:   if (portDone) state <= ST_SETTLE;
        ST_SETTLE: if (settleCnt == '0) state <= ST_MAIN;
        ST_MAIN:   if (portDone) state <= ST_SRC;
        ST_SRC:    if (portDone) state <= ST_PWRUP;
        ST_PWRUP:  if (pwrCnt == '0 && !devBusy) state <= ST_START_HI;
        ST_START_HI: if (portDone) state <= ST_START_LO;
        ST_START_LO: if (portDone) state <= ST_POLL;
        ST_POLL: begin
          if (portDone) begin
            devBusy <= portRdata[ACS_MAIN_BUSY];
            if (!portRdata[ACS_MAIN_BUSY]) state <= ST_RD_HI;
          end
        end
        ST_RD_HI, ST_CAL_HI: begin
          if (portDone) begin
            hiByte <= portRdata;
            state  <= (state == ST_RD_HI) ? ST_RD_LO : ST_CAL_LO;
          end
        end
        ST_RD_LO: begin
          if (portDone) begin
            result <= act.align ? {hiByte[3:0], portRdata} : {hiByte, portRdata[7:4]};
            state  <= act.autoOff ? ST_PWROFF : ST_IDLE;
          end
        end
        ST_CAL_LO: begin
          if (portDone) begin
            calib <= {hiByte, portRdata[7:4]};
            state <= ST_IDLE;
          end
        end
        ST_PWROFF: if (portDone) state <= ST_IDLE;
        default:   state <= ST_IDLE;
      endcase
    end
  end

  // shadow of what the device was last told, with the settle and power-up timers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tsOn      <= ACS_TEMP_RESET[ACS_TEMP_TEMP_SENSOR_ENABLE];
      bgOn      <= ACS_BG_RESET[0];
      pwrOn     <= 1'b0;
      devRef    <= ACS_REF_PIN;
      settleCnt <= '0;
      pwrCnt    <= '0;
    end else if (ce) begin
      if (settleCnt != '0) settleCnt <= settleCnt - 1'b1;
      if (pwrCnt != '0) pwrCnt <= pwrCnt - 1'b1;
      if (reqValid && reqData.we) begin
        case (reqData.addr)
          ACS_DEV_TEMP: begin
            tsOn <= reqData.wdata[ACS_TEMP_TEMP_SENSOR_ENABLE];
            if (reqData.wdata[ACS_TEMP_TEMP_SENSOR_ENABLE] && !tsOn)
              settleCnt <= ACS_CNT_W'(ACS_SETTLE_CYC);
          end
          ACS_DEV_BG:     bgOn <= reqData.wdata[0];
          ACS_DEV_SRCCLK: devRef <= reqData.wdata[ACS_REF_LSB +: 2];
          ACS_DEV_MAIN: begin
            pwrOn <= reqData.wdata[ACS_MAIN_PWR];
            if (reqData.wdata[ACS_MAIN_PWR] && !pwrOn)
              pwrCnt <= ACS_CNT_W'(ACS_POWERUP_CYC);
          end
          default: ;
        endcase
      end
    end
  end

  // path switch only while the device and the setting both choose the pin reference
  assign next_regulator_ref_path_switch = cfg.regulator_ref_path_switch && (cfg.refSel == ACS_REF_PIN) && (devRef == ACS_REF_PIN);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRefPathSwitch <= 1'b0;
    end else if (ce) begin
      regRefPathSwitch <= next_regulator_ref_path_switch;
    end
  end

  // checks on what the host drives into the device
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn || !ce);

  logic startWr;
  logic startClr;
  logic srcWr;
  assign startWr  = devReq.we && devReq.addr == ACS_DEV_MAIN && devReq.wdata[ACS_MAIN_START];
  assign startClr = devReq.we && devReq.addr == ACS_DEV_MAIN && !devReq.wdata[ACS_MAIN_START];
  assign srcWr    = devReq.we && devReq.addr == ACS_DEV_SRCCLK;

  sequence s_startRise;
    startWr;
  endsequence
  sequence s_startFall;
    ##[2:8] startClr;
  endsequence

  a_src_not_forbid: assert property (srcWr |-> devReq.wdata[7:5] != ACS_SRC_FORBID)
    else $error("forbidden source code written");
  a_chan_parked: assert property (srcWr && devReq.wdata[7:5] >= ACS_SRC_BG
      && devReq.wdata[7:5] <= ACS_SRC_OPP |-> isInternal && $past(state) == ST_SRC)
    else $error("internal source written without parked channel");
  a_regulator_ref_path_switch_off: assert property (devRef != ACS_REF_PIN |-> ##1 !regRefPathSwitch)
    else $error("regulator path switch on with internal reference");
  a_bandgap_first: assert property (srcWr && devReq.wdata[7:5] == ACS_SRC_BG |-> bgOn)
    else $error("bandgap selected before enable");
  a_reserved_one: assert property (devReq.we && devReq.addr == ACS_DEV_TEMP
      |-> devReq.wdata[ACS_TEMP_RSV])
    else $error("reserved sensor bit written as zero");
  a_settle_wait: assert property (startWr |-> settleCnt == '0 && pwrCnt == '0)
    else $error("start before settle or power-up delay");
  a_start_pulse: assert property (s_startRise |-> s_startFall)
    else $error("start bit not returned low");
  a_start_powered: assert property (startWr |-> devReq.wdata[ACS_MAIN_PWR] && pwrOn
      && $past(state, 3) == ST_PWRUP)
    else $error("start without power-up wait");
  a_div_range: assert property (startWr |-> adckNs(act.div) >= ACS_ADCK_MIN_NS
      && adckNs(act.div) <= ACS_ADCK_MAX_NS)
    else $error("converter clock period out of range");
  a_no_busy_start: assert property (startWr |-> !devBusy)
    else $error("start issued while device busy");
  a_auto_off: assert property (state == ST_PWROFF && portDone |-> ##1 !pwrOn)
    else $error("power enable not cleared after conversion");

endmodule : acs_host

// ### hw/acs_pkg.sv
package acs_pkg;

  // host-side register byte offsets
  localparam logic [7:0] ACS_CFG_OFS  = 8'h00;
  localparam logic [7:0] ACS_CMD_OFS  = 8'h04;
  localparam logic [7:0] ACS_STAT_OFS = 8'h08;
  localparam logic [7:0] ACS_RES_OFS  = 8'h0c;
  localparam logic [7:0] ACS_CAL_OFS  = 8'h10;
  localparam logic [2:0] ACS_CFG_IDX  = 3'h0;
  localparam logic [2:0] ACS_CMD_IDX  = 3'h1;
  localparam logic [2:0] ACS_STAT_IDX = 3'h2;
  localparam logic [2:0] ACS_RES_IDX  = 3'h3;
  localparam logic [2:0] ACS_CAL_IDX  = 3'h4;
  localparam int         ACS_NUM_REGS = 5;

  // command and status bits
  localparam int ACS_CMD_CONV   = 0;
  localparam int ACS_CMD_CAL    = 1;
  localparam int ACS_ST_BUSY    = 0;
  localparam int ACS_ST_DONE    = 1;
  localparam int ACS_ST_ERR     = 2;
  localparam int ACS_ST_DEVBUSY = 3;
  localparam int ACS_ST_TSON    = 4;
  localparam int ACS_ST_PWRON   = 5;

  // device register indices on the device port
  localparam logic [3:0] ACS_DEV_RES_LO = 4'h0;
  localparam logic [3:0] ACS_DEV_RES_HI = 4'h1;
  localparam logic [3:0] ACS_DEV_MAIN   = 4'h2;
  localparam logic [3:0] ACS_DEV_SRCCLK = 4'h3;
  localparam logic [3:0] ACS_DEV_TEMP   = 4'h4;
  localparam logic [3:0] ACS_DEV_BG     = 4'h5;
  localparam logic [3:0] ACS_DEV_CAL_HI = 4'h6;
  localparam logic [3:0] ACS_DEV_CAL_LO = 4'h7;

  // device field positions
  localparam int ACS_MAIN_START = 7;
  localparam int ACS_MAIN_BUSY  = 6;
  localparam int ACS_MAIN_PWR   = 5;
  localparam int ACS_MAIN_ALIGN = 4;
  localparam int ACS_SRC_LSB    = 5;
  localparam int ACS_REF_LSB    = 3;
  localparam int ACS_TEMP_RSV   = 1;
  localparam int ACS_TEMP_TEMP_SENSOR_ENABLE  = 0;
  localparam int ACS_CH_NONE    = 3;
  localparam logic [7:0] ACS_TEMP_RESET = 8'h02;
  localparam logic [7:0] ACS_BG_RESET   = 8'h00;

  // input source and reference codes
  localparam logic [2:0] ACS_SRC_EXT    = 3'h0;
  localparam logic [2:0] ACS_SRC_BG     = 3'h1;
  localparam logic [2:0] ACS_SRC_TSO    = 3'h2;
  localparam logic [2:0] ACS_SRC_OPP    = 3'h4;
  localparam logic [2:0] ACS_SRC_FORBID = 3'h7;
  localparam logic [1:0] ACS_REF_PIN    = 2'h0;
  localparam logic [1:0] ACS_REF_TS     = 2'h2;

  // timing
  localparam int ACS_CLK_PERIOD_NS   = 50;
  localparam int ACS_SETTLE_TIME_NS  = 200000;
  localparam int ACS_POWERUP_TIME_NS = 10000;
  localparam int ACS_SETTLE_CYC  =
    (ACS_SETTLE_TIME_NS + ACS_CLK_PERIOD_NS - 1) / ACS_CLK_PERIOD_NS;
  localparam int ACS_POWERUP_CYC =
    (ACS_POWERUP_TIME_NS + ACS_CLK_PERIOD_NS - 1) / ACS_CLK_PERIOD_NS;
  localparam int ACS_ADCK_MIN_NS = 500;
  localparam int ACS_ADCK_MAX_NS = 10000;
  localparam int ACS_TSCK_MIN_NS = 1000;
  localparam int ACS_TSCK_MAX_NS = 2000;
  localparam int ACS_CNT_W       = 12;

  typedef struct packed {
    logic       regulator_ref_path_switch;
    logic       autoOff;
    logic       bgEn;
    logic       temp_sensor_enable;
    logic       align;
    logic [2:0] div;
    logic [1:0] refSel;
    logic [3:0] chan;
    logic [2:0] src;
  } acs_cfg_s;

  typedef struct packed {
    logic       we;
    logic       re;
    logic [3:0] addr;
    logic [7:0] wdata;
  } acs_dreq_s;

  typedef enum logic [3:0] {
    ST_IDLE, ST_BG, ST_TEMP, ST_SETTLE, ST_MAIN, ST_SRC, ST_PWRUP, ST_START_HI,
    ST_START_LO, ST_POLL, ST_RD_HI, ST_RD_LO, ST_PWROFF, ST_CAL_HI, ST_CAL_LO
  } acs_state_e;

  typedef enum logic [1:0] {P_IDLE, P_ACT, P_CAP} acs_port_e;

endpackage : acs_pkg
